// ### map_pkg.sv
/*
  shared constants and types of the memory access and protection block.
  assumes: one 50 MHz clock, byte-wide sram and eeprom, 72-bit flash rows.
*/
package map_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int SRAM_AW = 13;          // 8 KB of sram
  localparam int BANK_AW = 12;          // 4 KB per bank
  localparam int BANK_COUNT = 2;
  localparam int ROW_BITS = 72;         // 8 data bytes plus 1 ecc byte
  localparam int ROW_AW = 13;           // rows in 64 KB main flash
  localparam int ECC_CHK_LSB = 64;      // hamming check bits
  localparam int ECC_CHK_BITS = 7;
  localparam int ECC_PAR_BIT = 71;      // overall parity bit
  localparam int BLOCK_DATA_BYTES = 256;
  localparam int BLOCK_ECC_BYTES = 32;
  localparam int BLOCK_COUNT = 256;
  localparam int EE_ROWS = 128;
  localparam int EE_ROW_BYTES = 16;
  localparam int EE_BYTES = EE_ROWS * EE_ROW_BYTES;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 50;
  localparam int EE_ROW_WRITE_NS = 20000;
  localparam int EE_WRITE_CYCLES = (EE_ROW_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam int EE_CNT_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is index times four
  localparam logic [2:0] IDX_LATCH0 = 3'h0;
  localparam logic [2:0] IDX_LATCH1 = 3'h1;
  localparam logic [2:0] IDX_LATCH2 = 3'h2;
  localparam logic [2:0] IDX_LATCH3 = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  localparam logic [2:0] IDX_EE_STAGE = 3'h5;
  localparam logic [2:0] IDX_EE_CMD = 3'h6;
  localparam logic [2:0] IDX_PROT = 3'h7;

  // latch field positions and factory values
  localparam int XRES_BIT = 7;
  localparam int ECC_EN_BIT = 2;
  localparam int DPS_LSB = 0;
  localparam int DLY_LSB = 4;
  localparam logic [7:0] LATCH0_RST = 8'h00;
  localparam logic [7:0] LATCH1_RST = 8'h00;
  localparam logic [7:0] LATCH2_RST = 8'h00;
  localparam logic [7:0] LATCH3_RST = 8'h01;

  // status, eeprom command and protection fields
  localparam int ST_ECC_SINGLE = 0;
  localparam int ST_ECC_DOUBLE = 1;
  localparam int ST_EE_BUSY = 2;
  localparam int ST_PROT_OPEN = 3;
  localparam int EE_IDX_LSB = 8;
  localparam int EE_ERASE_BIT = 8;
  localparam int EE_GO_BIT = 9;
  localparam int PROT_LVL_LSB = 8;
  localparam int PROT_LOCK_BIT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // encodings
  localparam logic [1:0] REGION_MAIN = 2'h0;
  localparam logic [1:0] REGION_ECC = 2'h1;
  localparam logic [1:0] REGION_EE = 2'h2;
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_FACTORY = 2'h1;
  localparam logic [1:0] PROT_FIELD = 2'h2;
  localparam logic [1:0] PROT_FULL = 2'h3;
  localparam logic [1:0] DRIVE_ANALOG_HIZ = 2'h0;
  localparam logic [1:0] DRIVE_DIGITAL_HIZ = 2'h1;
  localparam logic [1:0] DRIVE_PULL_UP = 2'h2;
  localparam logic [1:0] DRIVE_PULL_DOWN = 2'h3;
  localparam logic [1:0] DEBUG_JTAG5 = 2'h0;
  localparam logic [1:0] DEBUG_JTAG4 = 2'h1;
  localparam logic [1:0] DEBUG_SWD = 2'h2;
  localparam logic [1:0] DEBUG_OFF = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic req;
    logic we;
    logic [SRAM_AW-1:0] addr;
    logic [7:0] wdata;
  } map_sram_req_t;

  typedef struct packed {
    logic [63:0] data;
    logic singleErr;
    logic doubleErr;
  } map_ecc_t;

  typedef struct packed {
    logic [17:0] portResetDriveMode;
    logic extResetPinSelect;
    logic [1:0] debugPortSelect;
    logic eccSpaceEnable;
    logic [3:0] digitalClockPhaseDelay;
  } map_cfg_t;

  typedef enum logic [0:0] {FT_IDLE, FT_READ} map_fetch_t;

endpackage : map_pkg

// ### map_sram_bank.sv
/*
  one 4 KB sram bank: synchronous write, asynchronous read.
  assumes: the owner of the bank is chosen outside for each cycle.
*/
`timescale 1ns/100ps
module map_sram_bank
  import map_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // access
  input wire logic en,
  input wire logic we,
  input wire logic [BANK_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // storage of the bank
  logic [7:0] mem [0:(1<<BANK_AW)-1];

  // write on enable
  always_ff @(posedge sys_clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  // read path
  assign rdata = mem[addr];

endmodule : map_sram_bank

// ### map_top.sv
/*
  memory access and protection: sram arbiter, flash row fetch with ecc,
  protection check, eeprom read and row write, configuration latches.
  assumes: apb master on sys_clk, flash macro answers a row read with
  flashRdValid, programming engine reports progBusy and eraseAllDone.
*/
`timescale 1ns/100ps
// Summary of operation
// [R01] 8 KB sram shared by cpu and dma
// [R02] different banks parallel, same bank serialised
// [R03] secded per 8 bytes, error event out
// [R04] no instruction fetch from ecc section
// [R05] flash read one 9-byte row
// [R06] row data fills 8-byte instruction buffer
// [R07] programming stalls flash code fetch
// [R08] 256 blocks of 256 plus 32 bytes
// [R09] four levels, unprotected allows everything
// [R10] level change only after full erase
// [R11] factory level blocks external reads only
// [R12] field level blocks all external access
// [R13] full level allows internal reads only
// [R14] eeprom bytes read directly
// [R15] eeprom row write by command, fetch continues
// [R16] eeprom 128 rows of 16 bytes
// [R17] no eeprom ecc, no eeprom fetch
// [R18] four latch bytes applied at reset
// [R19] 2-bit port reset drive modes
// [R20] latch bit selects shared reset pin use
// [R21] 2-bit debug port selection
// [R22] latch bit enables ecc use
// [R23] 4-bit digital clock phase delay
// [R24] apply latches before ports leave reset
module map_top
  import map_pkg::*;
(
  // clock and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic porReset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sram ports
  input wire map_sram_req_t cpuSram,
  output logic cpuSramAck,
  output logic [7:0] cpuSramRdata,
  input wire map_sram_req_t dmaSram,
  output logic dmaSramAck,
  output logic [7:0] dmaSramRdata,
  // instruction fetch
  input wire logic fetchReq,
  input wire logic [17:0] fetchAddr,
  output logic fetchValid,
  output logic [7:0] fetchData,
  output logic fetchError,
  output logic eccErrorEvent,
  // flash macro
  output logic flashRdReq,
  output logic [ROW_AW-1:0] flashRdRow,
  input wire logic flashRdValid,
  input wire logic [ROW_BITS-1:0] flashRdData,
  // programming engine and protection check
  input wire logic progBusy,
  input wire logic eraseAllDone,
  input wire logic accReq,
  input wire logic accExt,
  input wire logic accWrite,
  input wire logic [7:0] accBlock,
  output logic accGrant,
  output logic accDeny,
  // eeprom read
  input wire logic eeRdReq,
  input wire logic [10:0] eeRdAddr,
  output logic eeRdValid,
  output logic [7:0] eeRdData,
  // applied configuration
  output map_cfg_t cfg,
  output logic ioRelease
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] latch [0:3];          // stored latch bytes
  logic applyDone;                  // latches applied since reset
  logic [1:0] protLevel [0:BLOCK_COUNT-1];
  logic protOpen;                   // level changes allowed
  logic eccSingle, eccDouble;       // sticky ecc status
  logic [7:0] eeMem [0:EE_BYTES-1];
  logic [7:0] eeStage [0:EE_ROW_BYTES-1];
  logic eeBusy, eeErase;
  logic [6:0] eeRow;
  logic [EE_CNT_W-1:0] eeCount;
  map_fetch_t state;
  logic [63:0] rowBuf;              // instruction buffer
  logic [ROW_AW-1:0] bufTag;
  logic bufValid;
  logic [2:0] fetchByte;
  logic dmaFirst;                   // conflict priority
  logic cpuWin, dmaWin, sameBank;
  logic bankEn [0:BANK_COUNT-1];
  logic bankWe [0:BANK_COUNT-1];
  logic [BANK_AW-1:0] bankAddr [0:BANK_COUNT-1];
  logic [7:0] bankWdata [0:BANK_COUNT-1];
  logic [7:0] bankRdata [0:BANK_COUNT-1];
  logic setup, wrEn, addrHit;
  logic [2:0] idx;
  logic [31:0] next_prdata;
  map_ecc_t dec;
  logic eccOn, rowDone;
  logic [63:0] useData;
  logic [ROW_AW-1:0] fetchRow;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  assign setup = psel && !penable;
  assign idx = paddr[4:2];
  assign addrHit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign wrEn = psel && penable && pready && pwrite && !pslverr;

  // read mux of all registers except the eeprom stage, which reads as zero
  always_comb begin
    next_prdata = '0;
    case (idx)
      IDX_LATCH0, IDX_LATCH1, IDX_LATCH2, IDX_LATCH3: begin
        next_prdata[7:0] = latch[idx[1:0]];
      end
      IDX_STATUS: begin
        next_prdata[ST_ECC_SINGLE] = eccSingle;
        next_prdata[ST_ECC_DOUBLE] = eccDouble;
        next_prdata[ST_EE_BUSY] = eeBusy;
        next_prdata[ST_PROT_OPEN] = protOpen;
      end
      IDX_EE_CMD: begin
        next_prdata[6:0] = eeRow;
        next_prdata[EE_ERASE_BIT] = eeErase;
        next_prdata[EE_GO_BIT] = eeBusy;
      end
      IDX_PROT: begin
        next_prdata[PROT_LVL_LSB +: 2] = protLevel[pwdata[7:0]];
        next_prdata[PROT_LOCK_BIT] = !protOpen;
      end
      default: begin
        next_prdata = '0;
      end
    endcase
  end

  // answer in the cycle after setup, unmapped gives an error
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= (addrHit && !pwrite) ? next_prdata : '0;
        pslverr <= !addrHit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration latches, kept across system reset
  // [R18] four stored latch bytes
  always_ff @(posedge sys_clk or negedge porReset_n) begin
    if (!porReset_n) begin
      latch[0] <= LATCH0_RST;
      latch[1] <= LATCH1_RST;
      latch[2] <= LATCH2_RST;
      latch[3] <= LATCH3_RST;
    end else if (wrEn && idx[2] == 1'b0) begin
      latch[idx[1:0]] <= pwdata[7:0];
    end
  end

  // [R24] apply first, release ports one cycle later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      applyDone <= 1'b0;
      ioRelease <= 1'b0;
      cfg <= '0;
    end else begin
      ioRelease <= applyDone;
      if (!applyDone) begin
        applyDone <= 1'b1;
        // [R19] drive mode fields per port
        cfg.portResetDriveMode <= {latch[2][1:0], latch[1], latch[0]};
        // [R20] shared reset pin function
        cfg.extResetPinSelect <= latch[2][XRES_BIT];
        // [R21] debug interface choice
        cfg.debugPortSelect <= latch[3][DPS_LSB +: 2];
        // [R22] ecc space use
        cfg.eccSpaceEnable <= latch[3][ECC_EN_BIT];
        // [R23] clock phase delay
        cfg.digitalClockPhaseDelay <= latch[3][DLY_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sram arbiter over two banks
  assign sameBank = cpuSram.addr[SRAM_AW-1] == dmaSram.addr[SRAM_AW-1];
  // [R02] parallel unless both target one bank
  assign cpuWin = cpuSram.req && !cpuSramAck &&
    !(dmaSram.req && !dmaSramAck && sameBank && dmaFirst);
  assign dmaWin = dmaSram.req && !dmaSramAck &&
    !(cpuSram.req && !cpuSramAck && sameBank && !dmaFirst);

  // route each bank to its owner
  always_comb begin
    for (int b = 0; b < BANK_COUNT; b++) begin
      bankEn[b] = 1'b0;
      bankWe[b] = 1'b0;
      bankAddr[b] = cpuSram.addr[BANK_AW-1:0];
      bankWdata[b] = cpuSram.wdata;
      if (cpuWin && cpuSram.addr[SRAM_AW-1] == 1'(b)) begin
        bankEn[b] = 1'b1;
        bankWe[b] = cpuSram.we;
      end else if (dmaWin && dmaSram.addr[SRAM_AW-1] == 1'(b)) begin
        bankEn[b] = 1'b1;
        bankWe[b] = dmaSram.we;
        bankAddr[b] = dmaSram.addr[BANK_AW-1:0];
        bankWdata[b] = dmaSram.wdata;
      end
    end
  end

  // [R01] two 4 KB banks make 8 KB
  for (genvar g = 0; g < BANK_COUNT; g++) begin : gBank
    map_sram_bank uBank (
      .sys_clk(sys_clk),
      .en(bankEn[g]),
      .we(bankWe[g]),
      .addr(bankAddr[g]),
      .wdata(bankWdata[g]),
      .rdata(bankRdata[g])
    );
  end

  // acks, read data and alternating conflict priority
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpuSramAck <= 1'b0;
      dmaSramAck <= 1'b0;
      cpuSramRdata <= '0;
      dmaSramRdata <= '0;
      dmaFirst <= 1'b0;
    end else begin
      cpuSramAck <= cpuWin;
      dmaSramAck <= dmaWin;
      if (cpuWin) begin
        cpuSramRdata <= bankRdata[cpuSram.addr[SRAM_AW-1]];
      end
      if (dmaWin) begin
        dmaSramRdata <= bankRdata[dmaSram.addr[SRAM_AW-1]];
      end
      if (cpuWin != dmaWin && cpuSram.req && dmaSram.req && sameBank) begin
        dmaFirst <= cpuWin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash row decode
  // [R03] single error corrected, double detected
  function automatic map_ecc_t eccDecode(input logic [ROW_BITS-1:0] row);
    logic [ROW_BITS-1:0] cw;
    logic [6:0] syn;
    logic par;
    int j;
    map_ecc_t r;
    cw = '0;
    syn = '0;
    j = 0;
    r = '0;
    for (int p = 1; p < ROW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = row[j];
        j++;
      end
    end
    for (int k = 0; k < ECC_CHK_BITS; k++) begin
      cw[1 << k] = row[ECC_CHK_LSB + k];
    end
    for (int p = 1; p < ROW_BITS; p++) begin
      if (cw[p]) begin
        syn = syn ^ 7'(p);
      end
    end
    par = (^cw) ^ row[ECC_PAR_BIT];
    if (par) begin
      cw[syn] = !cw[syn];
    end
    r.singleErr = par;
    r.doubleErr = (syn != 7'h00) && !par;
    j = 0;
    for (int p = 1; p < ROW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        r.data[j] = cw[p];
        j++;
      end
    end
    return r;
  endfunction : eccDecode

  assign dec = eccDecode(flashRdData);
  // [R22] without ecc the check byte is ignored
  assign eccOn = cfg.eccSpaceEnable;
  assign useData = eccOn ? dec.data : flashRdData[63:0];
  assign rowDone = (state == FT_READ) && flashRdValid;
  assign fetchRow = fetchAddr[15:3];

  ////////////////////////////////////////////////////////////////////////////
  // instruction fetch through the row buffer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= FT_IDLE;
      flashRdReq <= 1'b0;
      flashRdRow <= '0;
      fetchValid <= 1'b0;
      fetchData <= '0;
      fetchError <= 1'b0;
      eccErrorEvent <= 1'b0;
      rowBuf <= '0;
      bufTag <= '0;
      bufValid <= 1'b0;
      fetchByte <= '0;
    end else begin
      flashRdReq <= 1'b0;
      fetchValid <= 1'b0;
      eccErrorEvent <= 1'b0;
      // buffer contents may change under programming
      if (progBusy) begin
        bufValid <= 1'b0;
      end
      case (state)
        FT_IDLE: begin
          if (fetchReq && !fetchValid) begin
            // [R17] eeprom region refused as well
            // [R04] ecc section and eeprom never fetched
            if (fetchAddr[17:16] != REGION_MAIN) begin
              fetchValid <= 1'b1;
              fetchError <= 1'b1;
              fetchData <= '0;
            end else if (bufValid && bufTag == fetchRow && !progBusy) begin
              fetchValid <= 1'b1;
              fetchError <= 1'b0;
              fetchData <= rowBuf[{fetchAddr[2:0], 3'h0} +: 8];
            // [R07] no row read while programming runs
            end else if (!progBusy) begin
              // [R05] one whole row per read
              flashRdReq <= 1'b1;
              flashRdRow <= fetchRow;
              fetchByte <= fetchAddr[2:0];
              state <= FT_READ;
            end
          end
        end
        FT_READ: begin
          if (flashRdValid) begin
            // [R06] data bytes fill the buffer
            rowBuf <= useData;
            bufTag <= flashRdRow;
            bufValid <= !(eccOn && dec.doubleErr) && !progBusy;
            fetchValid <= 1'b1;
            fetchError <= eccOn && dec.doubleErr;
            fetchData <= useData[{fetchByte, 3'h0} +: 8];
            eccErrorEvent <= eccOn && (dec.singleErr || dec.doubleErr);
            state <= FT_IDLE;
          end
        end
        default: begin
          state <= FT_IDLE;
        end
      endcase
    end
  end

  // sticky ecc status, a new error wins over the clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eccSingle <= 1'b0;
      eccDouble <= 1'b0;
    end else begin
      eccSingle <= (rowDone && eccOn && dec.singleErr) || (eccSingle &&
        !(wrEn && idx == IDX_STATUS && pwdata[ST_ECC_SINGLE]));
      eccDouble <= (rowDone && eccOn && dec.doubleErr) || (eccDouble &&
        !(wrEn && idx == IDX_STATUS && pwdata[ST_ECC_DOUBLE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection levels per block
  // [R08] one level for each of 256 blocks
  // [R10] levels writable only after a full erase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      protOpen <= 1'b0;
      for (int i = 0; i < BLOCK_COUNT; i++) begin
        protLevel[i] <= PROT_NONE;
      end
    end else if (eraseAllDone) begin
      protOpen <= 1'b1;
      for (int i = 0; i < BLOCK_COUNT; i++) begin
        protLevel[i] <= PROT_NONE;
      end
    end else if (wrEn && idx == IDX_PROT && protOpen) begin
      protLevel[pwdata[7:0]] <= pwdata[PROT_LVL_LSB +: 2];
      protOpen <= !pwdata[PROT_LOCK_BIT];
    end
  end

  // access check answered one cycle after the request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      accGrant <= 1'b0;
      accDeny <= 1'b0;
    end else begin
      accGrant <= 1'b0;
      accDeny <= 1'b0;
      if (accReq) begin
        case (protLevel[accBlock])
          // [R09] unprotected allows all
          PROT_NONE: accGrant <= 1'b1;
          // [R11] external reads refused
          PROT_FACTORY: begin
            accGrant <= !(accExt && !accWrite);
            accDeny <= accExt && !accWrite;
          end
          // [R12] all external access refused
          PROT_FIELD: begin
            accGrant <= !accExt;
            accDeny <= accExt;
          end
          // [R13] internal reads only
          default: begin
            accGrant <= !accExt && !accWrite;
            accDeny <= accExt || accWrite;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eeprom
  // [R14] direct byte read, no ecc applied
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeRdValid <= 1'b0;
      eeRdData <= '0;
    end else begin
      eeRdValid <= eeRdReq;
      if (eeRdReq) begin
        eeRdData <= eeMem[eeRdAddr];
      end
    end
  end

  // staging bytes for the next row write
  always_ff @(posedge sys_clk) begin
    if (wrEn && idx == IDX_EE_STAGE) begin
      eeStage[pwdata[EE_IDX_LSB +: 4]] <= pwdata[7:0];
    end
  end

  // [R15] row command runs beside code fetch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeBusy <= 1'b0;
      eeErase <= 1'b0;
      eeRow <= '0;
      eeCount <= '0;
    end else if (eeBusy) begin
      eeCount <= eeCount - 1'b1;
      if (eeCount == '0) begin
        eeBusy <= 1'b0;
      end
    end else if (wrEn && idx == IDX_EE_CMD && pwdata[EE_GO_BIT]) begin
      eeBusy <= 1'b1;
      eeErase <= pwdata[EE_ERASE_BIT];
      eeRow <= pwdata[6:0];
      eeCount <= EE_CNT_W'(EE_WRITE_CYCLES - 1);
    end
  end

  // [R16] whole row of 16 bytes at once
  always_ff @(posedge sys_clk) begin
    if (eeBusy && eeCount == '0) begin
      for (int i = 0; i < EE_ROW_BYTES; i++) begin
        eeMem[{eeRow, 4'(i)}] <= eeErase ? 8'h00 : eeStage[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sram_parallel_a: assert property ( // [R02]
    cpuSram.req && dmaSram.req && !sameBank && !cpuSramAck && !dmaSramAck
    |=> cpuSramAck && dmaSramAck) else $error("banks not parallel");
  sram_serial_a: assert property ( // [R02]
    cpuSram.req && dmaSram.req && sameBank && !cpuSramAck && !dmaSramAck
    |=> cpuSramAck != dmaSramAck) else $error("same bank not serialised");
  ecc_double_a: assert property ( // [R03]
    rowDone && eccOn && dec.doubleErr
    |=> fetchValid && fetchError && eccErrorEvent)
    else $error("double error not flagged");
  no_ecc_fetch_a: assert property ( // [R04]
    state == FT_IDLE && fetchReq && !fetchValid &&
    fetchAddr[17:16] != REGION_MAIN |=> fetchError && !flashRdReq)
    else $error("fetch outside main flash");
  prog_stall_a: assert property ( // [R07]
    progBusy |=> !flashRdReq) else $error("row read during programming");
  factory_read_a: assert property ( // [R11]
    accReq && accExt && !accWrite && protLevel[accBlock] == PROT_FACTORY
    |=> accDeny && !accGrant) else $error("factory read not refused");
  full_write_a: assert property ( // [R13]
    accReq && !accExt && accWrite && protLevel[accBlock] == PROT_FULL
    |=> accDeny && !accGrant) else $error("full level write allowed");
  apply_order_a: assert property ( // [R24]
    $rose(ioRelease) |-> $past(applyDone))
    else $error("ports released before apply");

endmodule : map_top

// ### map_flash_model.sv
/* flash macro model: answers a row read three cycles later.
   assumes: one row read at a time, ecc byte left clear. */
`timescale 1ns/100ps
module map_flash_model
  import map_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // row read
  input wire logic flashRdReq,
  input wire logic [ROW_AW-1:0] flashRdRow,
  output logic flashRdValid = 1'h0,
  output logic [ROW_BITS-1:0] flashRdData = '0
);
  logic [1:0] pipe = 2'h0; // request delay line
  // row of eight data bytes and one ecc byte
  always @(posedge sys_clk) begin
    pipe <= {pipe[0], flashRdReq};
    flashRdValid <= pipe[1];
    // byte i is row low byte plus i, else a changing pattern
    for (int i = 0; i < 8; i++)
      flashRdData[8*i +: 8] <= pipe[1] ? flashRdRow[7:0] + 8'(i)
                                       : ~flashRdData[8*i +: 8];
  end
endmodule : map_flash_model

// ### map_top_tb_top.sv
/* bench of map_top: latches, fetch, sram arbitration, protection.
   assumes: flash model answers row reads, ecc off after first reset. */
`timescale 1ns/100ps
module map_top_tb_top
  import map_pkg::*;
;
  logic sys_clk = '0, reset_n = '0, porReset_n = '0, c;
  logic psel = '0, penable = '0, pwrite = '0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic cpuSramAck, dmaSramAck, fetchValid, fetchError, eccErrorEvent;
  logic flashRdReq, flashRdValid, accGrant, accDeny, eeRdValid, ioRelease;
  logic [7:0] cpuSramRdata, dmaSramRdata, fetchData, eeRdData;
  map_sram_req_t cpuSram = '0, dmaSram = '0;
  logic fetchReq = '0, progBusy = '0, eraseAllDone = '0, accReq = '0;
  logic accExt = '0, accWrite = '0, eeRdReq = '0;
  logic [17:0] fetchAddr = '0;
  logic [ROW_AW-1:0] flashRdRow;
  logic [ROW_BITS-1:0] flashRdData;
  logic [7:0] accBlock = '0;
  logic [10:0] eeRdAddr = '0;
  map_cfg_t cfg;
  int errors = 0, checks = 0, cyc = 0;
  map_top i_dut (.*);
  map_flash_model i_flash (.*);
  always #10 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) if (++cyc == 20000) begin
    errors++;
    print_verdict();
  end
  task print_verdict();
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // apb transfer, read data left in rd, error in c
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= '1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= '1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    c = pslverr;
    psel <= '0;
    penable <= '0;
  endtask : apb
  task fetch(input logic [17:0] a, input logic [7:0] d, input logic e);
    @(posedge sys_clk);
    fetchReq <= '1;
    fetchAddr <= a;
    do @(posedge sys_clk); while (fetchValid !== 1'h1);
    fetchReq <= '0;
    chk(fetchError, e);
    chk(eccErrorEvent, '0);
    if (!e) chk(fetchData, d);
  endtask : fetch
  task acc(input logic [7:0] b, input logic x, w, g);
    @(posedge sys_clk);
    accReq <= '1;
    accBlock <= b;
    accExt <= x;
    accWrite <= w;
    @(posedge sys_clk);
    accReq <= '0;
    @(posedge sys_clk);
    chk({accGrant, accDeny}, {g, !g});
  endtask : acc
  initial begin
    repeat (3) @(posedge sys_clk);
    chk(ioRelease, '0);
    reset_n <= '1;
    porReset_n <= '1;
    repeat (3) @(posedge sys_clk);
    chk({cfg, ioRelease}, {18'h0, 1'h0, DEBUG_JTAG4, 6'h1});
    for (int i = 0; i < 4; i++) begin
      apb('0, 12'(4 * i), '0);
      chk(rd, {31'h0, i == 3});
    end
    apb('0, 12'h20, '0);
    chk(c, 1'h1);
    fetch(18'h0002b, 8'h08, '0);
    fetch(18'h0002f, 8'h0c, '0);
    fetch(18'h1002b, 8'h00, '1);
    fetch(18'h2002b, 8'h00, '1);
    // programming holds back a fetch from the buffered row and drops the buffer
    @(posedge sys_clk);
    progBusy <= '1;
    fetchReq <= '1;
    fetchAddr <= 18'h0002d;
    repeat (4) begin
      @(posedge sys_clk);
      chk({flashRdReq, fetchValid}, '0);
    end
    progBusy <= '0;
    fetch(18'h0002d, 8'h0a, '0);
    // same bank: one now, the other a cycle later
    @(posedge sys_clk);
    cpuSram <= '{1'h1, 1'h1, 13'h1ffe, 8'ha5};
    dmaSram <= '{1'h1, 1'h1, 13'h1fff, 8'h3c};
    repeat (2) @(posedge sys_clk);
    c = cpuSramAck;
    chk(cpuSramAck ^ dmaSramAck, 1'h1);
    if (c) cpuSram.req <= '0;
    else dmaSram.req <= '0;
    @(posedge sys_clk);
    chk({cpuSramAck, dmaSramAck}, {!c, c});
    cpuSram <= '{1'h1, 1'h0, 13'h1fff, 8'h00};
    dmaSram <= '{1'h1, 1'h0, 13'h0000, 8'h00};
    repeat (2) @(posedge sys_clk);
    chk({cpuSramAck, dmaSramAck, cpuSramRdata}, 10'h33c);
    cpuSram.req <= '0;
    dmaSram <= '{1'h1, 1'h0, 13'h1ffe, 8'h00};
    repeat (2) @(posedge sys_clk);
    dmaSram.req <= '0;
    chk({dmaSramAck, dmaSramRdata}, 9'h1a5);
    apb('1, 12'h1c, 32'h0001_0303);
    apb('0, 12'h1c, 32'h0000_0003);
    chk(rd, 32'h0001_0000);
    acc(8'h03, '1, '0, '1);
    @(posedge sys_clk);
    eraseAllDone <= '1;
    @(posedge sys_clk);
    eraseAllDone <= '0;
    for (int l = 1; l < 4; l++) begin
      apb('1, 12'h1c, {15'h0, l == 3, 6'h0, 2'(l), 8'(2 + l)});
      for (int k = 0; k < 4; k++)
        acc(8'(2 + l), k[1], k[0], k[1] ? k[0] && l == PROT_FACTORY
                                        : !(k[0] && l == PROT_FULL));
    end
    // eeprom row write beside a fetch, then a byte read
    apb('1, 12'h14, 32'h0000_035a);
    apb('1, 12'h18, 32'h0000_0207);
    apb('0, 12'h10, '0);
    chk(rd[ST_EE_BUSY], 1'h1);
    fetch(18'h0003a, 8'h09, '0);
    do apb('0, 12'h10, '0); while (rd[ST_EE_BUSY]);
    @(posedge sys_clk);
    eeRdReq <= '1;
    eeRdAddr <= 11'h073;
    @(posedge sys_clk);
    eeRdReq <= '0;
    @(posedge sys_clk);
    chk({eeRdValid, eeRdData}, 9'h15a);
    apb('1, 12'h0, 32'haa);
    apb('1, 12'h4, 32'haa);
    apb('1, 12'h8, 32'h82);
    apb('1, 12'hc, 32'h96);
    apb('0, 12'hc, '0);
    chk(rd, 32'h96);
    @(posedge sys_clk);
    reset_n <= '0;
    @(posedge sys_clk);
    reset_n <= '1;
    repeat (3) @(posedge sys_clk);
    chk({cfg, ioRelease}, {18'h2aaaa, 1'h1, DEBUG_SWD, 6'h33});
    print_verdict();
  end
endmodule : map_top_tb_top
